// File: hw/ttr_pkg.sv
// Constants for the thermistor threshold register bank.
// Assumes a single 10 MHz clock and a synchronous, active-high reset.
package ttr_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] TTR_OFS_WARM_REDUCE = 8'h61;
    localparam logic [7:0] TTR_OFS_WARM = 8'h64;
    localparam logic [7:0] TTR_OFS_HOT = 8'h65;
    localparam logic [7:0] TTR_OFS_PART_ID = 8'h6f;
    localparam logic [7:0] TTR_OFS_CHG_CFG = 8'h70;
    localparam logic [7:0] TTR_OFS_CHG_CODE = 8'h71;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TTR_RST_WARM_REDUCE = 8'h34;
    localparam logic [7:0] TTR_RST_WARM = 8'h38;
    localparam logic [7:0] TTR_RST_HOT = 8'h27;
    localparam logic [7:0] TTR_RST_CHG_CFG = 8'h01;
    localparam logic [7:0] TTR_RST_CHG_CODE = 8'h08;
    // Arbitrary neutral identifier value
    localparam logic [7:0] TTR_PART_ID = 8'h5a;
    localparam logic [6:0] TTR_DEV_ADDR = 7'h36;
    localparam logic [7:0] TTR_UNMAPPED = 8'h00;
    // ----------------------------------------------------------------
    // Field positions, scale and byte-count constants, bus states
    // ----------------------------------------------------------------
    localparam int TTR_VRED_HI = 6;
    localparam int TTR_VRED_LO = 4;
    localparam int TTR_IRED_HI = 2;
    localparam int TTR_IRED_LO = 0;
    localparam int TTR_STEP_BIT = 0;
    localparam logic [3:0] TTR_FULL_SCALE = 4'h8;
    localparam logic [3:0] TTR_BITS_PER_BYTE = 4'h8;
    typedef enum {
        TTR_IDLE, TTR_ADDR, TTR_ACK_ADDR, TTR_REG, TTR_ACK_REG,
        TTR_WDATA, TTR_ACK_W, TTR_RDATA, TTR_RACK
    } ttr_state_t;
endpackage

// File: hw/ttr_regs.sv
// Thermistor threshold register bank with its two-wire slave port,
// temperature zone logic, charge current scaling and push-button event.
// Assumes scl/sda and all other inputs are synchronous to ref_clk.
//
// Summary of operation
// - Warm threshold register, read/write at 0x64, resets to 0x38.
// - Thresholds are unsigned binary voltages, LSB 4.688 mV, MSB 600 mV.
// - Hot threshold register, read/write at 0x65, resets to 0x27.
// - Read-only part identifier at 0x6F returns a fixed code, ignores writes.
// - Charge code counts 2.5 mA with step bit set, 1.25 mA when clear.
// - A push-button press raises a host event; holding it requests reset.
// - Charging is controlled by where the sensed voltage lies versus thresholds.
// - Warm zone lowers target voltage and current; defaults 150 mV and half.
`timescale 1ns/1ps
module ttr_regs import ttr_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    input wire logic [7:0] thermistorSense,
    input wire logic thermistorValid,
    input wire logic pushbuttonInput_n,
    output logic buttonEvent,
    output logic sysResetReq,
    output logic chargeEnable,
    output logic warmActive,
    output logic [2:0] warmVoltageReduction,
    output logic [12:0] chargeCurrent
);
    // ----------------------------------------------------------------
    // Bus edge detection
    // ----------------------------------------------------------------
    logic sclPrev_q, sdaPrev_q;
    wire sclRise = scl && !sclPrev_q;
    wire sclFall = !scl && sclPrev_q;
    wire startCond = scl && sclPrev_q && sdaPrev_q && !sdaIn;
    wire stopCond = scl && sclPrev_q && !sdaPrev_q && sdaIn;

    ttr_state_t state_q, state_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic rw_q, rw_d, nack_q, nack_d;
    logic [7:0] warm_q, hot_q, warmReduce_q, chgCfg_q, chgCode_q;
    logic regWe;
    wire byteDone = (cnt_q == TTR_BITS_PER_BYTE);

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    wire [7:0] readData =
        (ptr_q == TTR_OFS_WARM) ? warm_q :
        (ptr_q == TTR_OFS_HOT) ? hot_q :
        (ptr_q == TTR_OFS_PART_ID) ? TTR_PART_ID :
        (ptr_q == TTR_OFS_WARM_REDUCE) ? warmReduce_q :
        (ptr_q == TTR_OFS_CHG_CFG) ? chgCfg_q :
        (ptr_q == TTR_OFS_CHG_CODE) ? chgCode_q : TTR_UNMAPPED;

    wire driveLow = (state_q == TTR_ACK_ADDR) || (state_q == TTR_ACK_REG) ||
        (state_q == TTR_ACK_W) || ((state_q == TTR_RDATA) && !shift_q[7]);
    assign sdaOut = 1'b0;
    assign sdaOe_n = !driveLow;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        rw_d = rw_q;
        nack_d = nack_q;
        regWe = 1'b0;
        if (startCond) begin
            state_d = TTR_ADDR;
            cnt_d = '0;
        end else if (stopCond) begin
            state_d = TTR_IDLE;
        end else if (sclRise) begin
            if (state_q == TTR_RACK) begin
                nack_d = sdaIn;
            end else if (state_q != TTR_RDATA) begin
                shift_d = {shift_q[6:0], sdaIn};
            end
            cnt_d = cnt_q + 4'h1;
        end else if (sclFall) begin
            case (state_q)
                TTR_ADDR: if (byteDone) begin
                    rw_d = shift_q[0];
                    state_d = (shift_q[7:1] == TTR_DEV_ADDR) ? TTR_ACK_ADDR : TTR_IDLE;
                end
                TTR_ACK_ADDR: begin
                    cnt_d = '0;
                    shift_d = readData;
                    state_d = rw_q ? TTR_RDATA : TTR_REG;
                end
                TTR_REG: if (byteDone) begin
                    ptr_d = shift_q;
                    state_d = TTR_ACK_REG;
                end
                TTR_ACK_REG: begin
                    cnt_d = '0;
                    state_d = TTR_WDATA;
                end
                TTR_WDATA: if (byteDone) begin
                    regWe = 1'b1;
                    state_d = TTR_ACK_W;
                end
                TTR_ACK_W: begin
                    cnt_d = '0;
                    ptr_d = ptr_q + 8'h01;
                    state_d = TTR_WDATA;
                end
                TTR_RDATA: begin
                    if (byteDone) begin
                        ptr_d = ptr_q + 8'h01;
                        cnt_d = '0;
                        state_d = TTR_RACK;
                    end else begin
                        shift_d = {shift_q[6:0], 1'b0};
                    end
                end
                TTR_RACK: begin
                    cnt_d = '0;
                    shift_d = readData;
                    state_d = nack_q ? TTR_IDLE : TTR_RDATA;
                end
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        sclPrev_q <= scl;
        sdaPrev_q <= sdaIn;
        if (rst) begin
            state_q <= TTR_IDLE;
            shift_q <= '0;
            ptr_q <= '0;
            cnt_q <= '0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
        end
    end

    // ----------------------------------------------------------------
    // Register file; the identifier has no write path
    // ----------------------------------------------------------------
    wire weWarm = regWe && (ptr_q == TTR_OFS_WARM);
    wire weHot = regWe && (ptr_q == TTR_OFS_HOT);
    wire weReduce = regWe && (ptr_q == TTR_OFS_WARM_REDUCE);
    wire weCfg = regWe && (ptr_q == TTR_OFS_CHG_CFG);
    wire weCode = regWe && (ptr_q == TTR_OFS_CHG_CODE);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            warm_q <= TTR_RST_WARM;
            hot_q <= TTR_RST_HOT;
            warmReduce_q <= TTR_RST_WARM_REDUCE;
            chgCfg_q <= TTR_RST_CHG_CFG;
            chgCode_q <= TTR_RST_CHG_CODE;
        end else begin
            if (weWarm) warm_q <= shift_q;
            if (weHot) hot_q <= shift_q;
            if (weReduce) warmReduce_q <= shift_q;
            if (weCfg) chgCfg_q <= shift_q;
            if (weCode) chgCode_q <= shift_q;
        end
    end

    // ----------------------------------------------------------------
    // Temperature zones
    // ----------------------------------------------------------------
    // NTC divider: hotter battery gives lower voltage, so compare with <=.
    // Live registers are compared, so a new threshold needs no extra command.
    wire isHot = (thermistorSense <= hot_q);
    wire isWarm = !isHot && (thermistorSense <= warm_q);
    logic hot_q2, warm_q2;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hot_q2 <= 1'b0;
            warm_q2 <= 1'b0;
        end else if (thermistorValid) begin
            hot_q2 <= isHot;
            warm_q2 <= isWarm;
        end
    end
    assign chargeEnable = !hot_q2;
    assign warmActive = warm_q2;

    // ----------------------------------------------------------------
    // Charge current scaling, units of 1.25 mA / 8
    // ----------------------------------------------------------------
    wire stepSel = chgCfg_q[TTR_STEP_BIT];
    wire [8:0] baseUnits = stepSel ? {chgCode_q, 1'b0} : {1'b0, chgCode_q};
    wire [3:0] scale = warm_q2 ?
        (TTR_FULL_SCALE - {1'b0, warmReduce_q[TTR_IRED_HI:TTR_IRED_LO]}) : TTR_FULL_SCALE;
    wire [12:0] scaled = 13'(baseUnits * scale);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chargeCurrent <= '0;
            warmVoltageReduction <= '0;
        end else begin
            chargeCurrent <= hot_q2 ? 13'h0000 : scaled;
            warmVoltageReduction <= warm_q2 ?
                warmReduce_q[TTR_VRED_HI:TTR_VRED_LO] : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Push-button
    // ----------------------------------------------------------------
    logic btnPrev_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            btnPrev_q <= 1'b0;
            buttonEvent <= 1'b0;
            sysResetReq <= 1'b0;
        end else begin
            btnPrev_q <= !pushbuttonInput_n;
            buttonEvent <= !pushbuttonInput_n && !btnPrev_q;
            sysResetReq <= !pushbuttonInput_n && btnPrev_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence pressSeq;
        !pushbuttonInput_n && !btnPrev_q;
    endsequence
    sequence eventPulse;
        buttonEvent ##1 !buttonEvent;
    endsequence
    warm_reset_a: assert property (@(posedge ref_clk) rst |=> warm_q == TTR_RST_WARM)
        else $error("warm threshold reset value wrong");
    hot_reset_a: assert property (@(posedge ref_clk) rst |=> hot_q == TTR_RST_HOT)
        else $error("hot threshold reset value wrong");
    id_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == TTR_ACK_ADDR) && rw_q && sclFall && ptr_q == TTR_OFS_PART_ID
        |=> shift_q == TTR_PART_ID) else $error("identifier read wrong");
    id_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        regWe && ptr_q == TTR_OFS_PART_ID |=> $stable(warm_q) && $stable(hot_q))
        else $error("identifier write changed registers");
    // Settings are taken one cycle back, so a write landing on the check edge is no hazard
    step_scale_a: assert property (@(posedge ref_clk) disable iff (rst)
        !hot_q2 && !warm_q2
        |=> chargeCurrent == ($past(chgCfg_q[TTR_STEP_BIT]) ?
            13'($past(chgCode_q)) * 13'd16 : 13'($past(chgCode_q)) * 13'd8))
        else $error("charge current scaling wrong");
    button_evt_a: assert property (@(posedge ref_clk) disable iff (rst)
        pressSeq |=> eventPulse) else $error("button event missing");
    hot_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        thermistorValid && thermistorSense <= hot_q |=> !chargeEnable)
        else $error("hot zone did not stop charging");
    new_thresh_a: assert property (@(posedge ref_clk) disable iff (rst)
        thermistorValid && thermistorSense > hot_q && thermistorSense <= warm_q
        |=> warmActive ##1 warmVoltageReduction == warmReduce_q[TTR_VRED_HI:TTR_VRED_LO])
        else $error("warm threshold not applied");
endmodule

// File: tb/ttr_host.sv
// Host model: a two-wire bus master for the register bank.
// Assumes sdaBus is the resolved open-drain line with a pull-up.
`timescale 1ns/1ps
module ttr_host (
    input wire logic ref_clk,
    input wire logic sdaBus,
    output logic scl,
    output logic sdaDrv
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Each phase lasts four clocks, so the design sees every edge apart
    task automatic step(input logic c, input logic d);
        @(posedge ref_clk);
        scl <= c;
        sdaDrv <= d;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic start();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Data moves only while scl is low; the line is sampled while scl is high
    task automatic xfer(input logic d, output logic q);
        step(1'b0, d);
        step(1'b1, d);
        q = sdaBus;
        step(1'b0, d);
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xfer(b[i], q);
        end
        xfer(1'b1, q);
        ack = ~q;
    endtask
    task automatic recvByte(output logic [7:0] b, input logic nack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, b[i]);
        end
        xfer(nack, q);
    endtask
endmodule

// File: tb/tb_thermistor_threshold_regs.sv
// Self-checking bench for the thermistor threshold register bank.
// Assumes the host model in ttr_host.sv and the package constants.
`timescale 1ns/1ps
module tb_thermistor_threshold_regs import ttr_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic btn_n = 1'b1;
    logic [7:0] sense = 8'h00;
    logic scl, sdaDrv, sdaOut, sdaOe_n, bEvt, sysRst, chgEn, warm;
    logic [2:0] vRed;
    logic [12:0] iChg;
    int err_count = 0;
    int check_count = 0;
    wire sdaBus = sdaDrv & (sdaOe_n | sdaOut);
    always #50 ref_clk = ~ref_clk;
    ttr_host host_u (.ref_clk(ref_clk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));
    ttr_regs dut_u (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .thermistorSense(sense),
        .thermistorValid(valid), .pushbuttonInput_n(btn_n), .buttonEvent(bEvt),
        .sysResetReq(sysRst), .chargeEnable(chgEn), .warmActive(warm),
        .warmVoltageReduction(vRed), .chargeCurrent(iChg));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic a1, a2, a3;
        host_u.start();
        host_u.sendByte({TTR_DEV_ADDR, 1'b0}, a1);
        host_u.sendByte(ptr, a2);
        host_u.sendByte(d, a3);
        host_u.stop();
        check("write acks", {a1, a2, a3}, 24'h7);
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic a1, a2, a3;
        host_u.start();
        host_u.sendByte({TTR_DEV_ADDR, 1'b0}, a1);
        host_u.sendByte(ptr, a2);
        host_u.start();
        host_u.sendByte({TTR_DEV_ADDR, 1'b1}, a3);
        host_u.recvByte(d, 1'b1);
        host_u.stop();
        check("read acks", {a1, a2, a3}, 24'h7);
    endtask
    task automatic sample(input logic [7:0] v, input logic [4:0] ew, input logic [12:0] i);
        @(posedge ref_clk);
        sense <= v;
        valid <= 1'b1;
        @(posedge ref_clk);
        valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("zone outputs", {chgEn, warm, vRed, iChg}, {ew, i});
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        check("base current", iChg, 24'd128);
        rd(TTR_OFS_WARM, d);
        check("warm reset", d, 24'h38);
        rd(TTR_OFS_HOT, d);
        check("hot reset", d, 24'h27);
        rd(TTR_OFS_PART_ID, d);
        check("part id", d, TTR_PART_ID);
        rd(TTR_OFS_WARM_REDUCE, d);
        check("warm reduce reset", d, 24'h34);
        rd(TTR_UNMAPPED, d);
        check("unmapped read", d, 24'h0);
    endtask
    task automatic t_regs();
        logic [7:0] d;
        wr(TTR_OFS_WARM, 8'h40);
        wr(TTR_OFS_HOT, 8'h20);
        wr(TTR_OFS_PART_ID, 8'hff);
        rd(TTR_OFS_WARM, d);
        check("warm write", d, 24'h40);
        rd(TTR_OFS_HOT, d);
        check("hot write", d, 24'h20);
        rd(TTR_OFS_PART_ID, d);
        check("part id kept", d, TTR_PART_ID);
    endtask
    // Codes are unsigned binary, so boundaries are one count apart
    task automatic t_zone();
        sample(8'h20, 5'b00000, 13'd0);
        sample(8'h21, 5'b11011, 13'd64);
        sample(8'h40, 5'b11011, 13'd64);
        sample(8'h41, 5'b10000, 13'd128);
        wr(TTR_OFS_CHG_CFG, 8'h00);
        sample(8'h41, 5'b10000, 13'd64);
        wr(TTR_OFS_WARM, 8'h50);
        sample(8'h41, 5'b11011, 13'd32);
        // 250 mV step and 0.875 of 20 mA at the small step
        wr(TTR_OFS_WARM_REDUCE, 8'h51);
        wr(TTR_OFS_CHG_CODE, 8'h10);
        sample(8'h41, 5'b11101, 13'd112);
    endtask
    task automatic t_btn();
        int pulses;
        pulses = 0;
        @(posedge ref_clk);
        btn_n <= 1'b0;
        repeat (4) begin
            @(posedge ref_clk);
            #1;
            pulses += (bEvt === 1'b1);
        end
        check("button pulses", pulses[23:0], 24'd1);
        check("reset request", sysRst, 24'd1);
        @(posedge ref_clk);
        btn_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("reset released", {bEvt, sysRst}, 24'd0);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        t_reset();
        t_regs();
        t_zone();
        t_btn();
        report_and_stop();
    end
    // Whole run needs about 6200 clocks
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        report_and_stop();
    end
endmodule
